/* include/ssc_cfg.svh */
// Constants for the synchronous serial clock and shift core
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
`define SSC_DIV_W 12
`define SSC_DIV_MAX 12'hfff
`define SSC_WORD_W 32
`define SSC_LEN_W 6
`define SSC_LEN_RST 6'h08
`define SSC_ST_TRANSMIT_READY_FLAG 0
`define SSC_ST_TRANSMITTER_EMPTY_FLAG 1
`define SSC_ST_RECEIVE_READY_FLAG 2
`define SSC_ST_OVR 3
`define SSC_ST_W 4
`endif

/* include/ssc_pkg.sv */
// Types for the synchronous serial clock and shift core
package ssc_pkg;
	typedef enum logic [1:0] {
		SSC_SRC_DIV = 2'b00,
		SSC_SRC_OTHER = 2'b01,
		SSC_SRC_PIN = 2'b10
	} ssc_src_t;
	typedef enum logic [1:0] {
		SSC_START_CONT = 2'b00,
		SSC_START_OTHER = 2'b01,
		SSC_START_FS_RISE = 2'b10,
		SSC_START_FS_FALL = 2'b11
	} ssc_start_t;
	typedef enum logic [1:0] {
		SSC_CKO_NONE = 2'b00,
		SSC_CKO_CONT = 2'b01,
		SSC_CKO_XFER = 2'b10
	} ssc_cko_t;
endpackage

/* verilog/ssc_clk_div.sv */
// Shared clock divider producing a 50 percent divided clock and its edge enables
`timescale 1ns/1ps
`default_nettype none
`include "ssc_cfg.svh"
module ssc_clk_div #(
	parameter int DIV_W = `SSC_DIV_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [DIV_W-1:0] ratio,
	output logic div_clk,
	output logic div_rise,
	output logic div_fall
);
	logic [DIV_W-1:0] cnt_r, cnt_nxt;
	logic lvl_r, lvl_nxt;
	always_comb begin
		cnt_nxt = cnt_r;
		lvl_nxt = lvl_r;
		if (ratio == '0) begin
			cnt_nxt = '0; // RQ2
			lvl_nxt = 1'b0;
		end else if (cnt_r >= ratio - 1'b1) begin
			cnt_nxt = '0; // RQ4
			lvl_nxt = ~lvl_r; // RQ3
		end else begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_r <= '0;
			lvl_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			lvl_r <= lvl_nxt;
		end
	end
	assign div_clk = lvl_r;
	assign div_rise = lvl_nxt & ~lvl_r;
	assign div_fall = ~lvl_nxt & lvl_r;
endmodule
`default_nettype wire

/* verilog/ssc_core.sv */
// Synchronous serial core: clock selection and transmit and receive shift datapaths
// Contract
// [RQ1] Clock ratio field is 12 bits, up to 4095, dividing by up to 8190.
// [RQ2] Ratio zero keeps the divider idle with no divided clock.
// [RQ3] Ratio one or more gives system clock over twice the ratio.
// [RQ4] Each divided clock phase lasts exactly ratio system clock periods.
// [RQ5] The divided clock feeds both receive and transmit sections.
// [RQ6] Transmit bit clock comes from its pin, receive clock or divider.
// [RQ7] Receive bit clock comes from its pin, transmit clock or divider.
// [RQ8] Internal clocks invert independently; pins are unaffected by inversion.
// [RQ9] Each clock pin drives continuously or only during transfer.
// [RQ10] Software must not pick own pin as source with continuous output.
// [RQ11] Receive pin clock at most system clock over two or three.
// [RQ12] Transmit pin clock at most system clock over six or two.
// [RQ13] Sections run independently but may share clock and start together.
// [RQ14] Transmitter starts frames only on its start event.
// [RQ15] Holding word moves to shift register and shifts out on bit clock.
// [RQ16] Transmitter empty flag set when holding and shift registers empty.
// [RQ17] Transmit ready set when holding word moves into shift register.
// [RQ18] Receiver starts frames only on its start event.
// [RQ19] Full received word copies to holding register and sets receive ready.
// [RQ20] New word before read sets overflow and still overwrites holding.
// [RQ21] Interrupt output high while any unmasked status is pending.
// [RQ22] Loopback feeds transmit data, sync and clock into the receiver.
// [RQ23] Enable writes set mask bits, disable writes clear them.
// [RQ24] Holding write clears ready and empty; receive read clears receive ready.
// [RQ25] Pin clocks and frame syncs pass a two flop synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_cfg.svh"
module ssc_core #(
	parameter int DIV_W = `SSC_DIV_W,
	parameter int WORD_W = `SSC_WORD_W,
	parameter int LEN_W = `SSC_LEN_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [DIV_W-1:0] clock_ratio, // RQ1
	input wire ssc_pkg::ssc_src_t tx_src,
	input wire ssc_pkg::ssc_src_t rx_src,
	input wire logic tx_invert,
	input wire logic rx_invert,
	input wire ssc_pkg::ssc_cko_t tx_cko,
	input wire ssc_pkg::ssc_cko_t rx_cko,
	input wire ssc_pkg::ssc_start_t tx_start,
	input wire ssc_pkg::ssc_start_t rx_start,
	input wire logic [LEN_W-1:0] word_len,
	input wire logic msb_first,
	input wire logic tx_enable,
	input wire logic rx_enable,
	input wire logic loopback,
	input wire logic [WORD_W-1:0] thr_wdata,
	input wire logic thr_write,
	output logic [WORD_W-1:0] rhr_rdata,
	input wire logic rhr_read,
	input wire logic [`SSC_ST_W-1:0] int_enable_wr,
	input wire logic [`SSC_ST_W-1:0] int_disable_wr,
	output logic [`SSC_ST_W-1:0] int_mask,
	output logic [`SSC_ST_W-1:0] status,
	output logic irq,
	input wire logic tx_bit_clock_pin_in,
	output logic tx_bit_clock_pin_out,
	output logic tx_bit_clock_pin_oe,
	input wire logic rx_bit_clock_pin_in,
	output logic rx_bit_clock_pin_out,
	output logic rx_bit_clock_pin_oe,
	input wire logic tx_frame_sync_pin_in,
	input wire logic rx_frame_sync_pin_in,
	input wire logic rx_serial_in,
	output logic tx_serial_out,
	output logic tx_busy,
	output logic rx_busy
);
	logic div_clk, div_rise, div_fall;
	ssc_clk_div #(.DIV_W(DIV_W)) u_div (
		.clk(clk),
		.rstn(rstn),
		.ratio(clock_ratio),
		.div_clk(div_clk),
		.div_rise(div_rise),
		.div_fall(div_fall)
	);
	// Two-flop synchronisers for pin inputs
	logic [4:0] s1_r, s2_r, s3_r;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= {rx_serial_in, rx_frame_sync_pin_in, tx_frame_sync_pin_in,
				rx_bit_clock_pin_in, tx_bit_clock_pin_in}; // RQ25
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	logic tk_s, rk_s, tf_s, rf_s, rd_s;
	logic tk_p, rk_p, tf_p, rf_p;
	assign {rd_s, rf_s, tf_s, rk_s, tk_s} = s2_r;
	assign {rf_p, tf_p, rk_p, tk_p} = s3_r[3:0];
	// Clock selection as level plus rise and fall enables
	logic tclk, trise, tfall, rclk, rrise, rfall;
	logic tk_lvl, tk_r, tk_f;
	always_comb begin
		unique case (tx_src)
			ssc_pkg::SSC_SRC_PIN: begin // RQ6
				tk_lvl = tk_s;
				tk_r = tk_s & ~tk_p;
				tk_f = ~tk_s & tk_p;
			end
			ssc_pkg::SSC_SRC_OTHER: begin
				tk_lvl = (rx_src == ssc_pkg::SSC_SRC_PIN) ? rk_s : div_clk; // RQ13
				tk_r = (rx_src == ssc_pkg::SSC_SRC_PIN) ? (rk_s & ~rk_p) : div_rise;
				tk_f = (rx_src == ssc_pkg::SSC_SRC_PIN) ? (~rk_s & rk_p) : div_fall;
			end
			default: begin
				tk_lvl = div_clk; // RQ5
				tk_r = div_rise;
				tk_f = div_fall;
			end
		endcase
		tclk = tk_lvl ^ tx_invert; // RQ8
		trise = tx_invert ? tk_f : tk_r;
		tfall = tx_invert ? tk_r : tk_f;
	end
	logic rk_lvl, rk_r, rk_f;
	always_comb begin
		if (loopback) begin
			rk_lvl = tk_lvl; // RQ22
			rk_r = tk_r;
			rk_f = tk_f;
		end else begin
			unique case (rx_src)
				ssc_pkg::SSC_SRC_PIN: begin // RQ7
					rk_lvl = rk_s;
					rk_r = rk_s & ~rk_p;
					rk_f = ~rk_s & rk_p;
				end
				ssc_pkg::SSC_SRC_OTHER: begin
					rk_lvl = tk_lvl;
					rk_r = tk_r;
					rk_f = tk_f;
				end
				default: begin
					rk_lvl = div_clk; // RQ5
					rk_r = div_rise;
					rk_f = div_fall;
				end
			endcase
		end
		rclk = rk_lvl ^ rx_invert; // RQ8
		rrise = rx_invert ? rk_f : rk_r;
		rfall = rx_invert ? rk_r : rk_f;
	end
	// Transmit datapath; shifts on falling edge of internal clock
	logic [WORD_W-1:0] thr_r, thr_nxt, tsr_r, tsr_nxt;
	logic thr_full_r, thr_full_nxt, tx_act_r, tx_act_nxt;
	logic [LEN_W-1:0] tcnt_r, tcnt_nxt;
	logic transmit_ready_flag_r, transmit_ready_flag_nxt, txe_r, txe_nxt, td_r, td_nxt;
	logic rx_start_ev_tx;
	logic tfs, tfs_prev, tx_go;
	assign tfs = loopback ? tf_s : tf_s;
	assign tfs_prev = tf_p;
	always_comb begin
		unique case (tx_start)
			ssc_pkg::SSC_START_CONT: tx_go = 1'b1;
			ssc_pkg::SSC_START_OTHER: tx_go = rx_start_ev_tx; // RQ13
			ssc_pkg::SSC_START_FS_RISE: tx_go = tfs & ~tfs_prev;
			ssc_pkg::SSC_START_FS_FALL: tx_go = ~tfs & tfs_prev;
		endcase
	end
	always_comb begin
		thr_nxt = thr_r;
		tsr_nxt = tsr_r;
		thr_full_nxt = thr_full_r;
		tx_act_nxt = tx_act_r;
		tcnt_nxt = tcnt_r;
		transmit_ready_flag_nxt = transmit_ready_flag_r;
		txe_nxt = txe_r;
		td_nxt = td_r;
		if (thr_write) begin
			thr_nxt = thr_wdata;
			thr_full_nxt = 1'b1;
			transmit_ready_flag_nxt = 1'b0; // RQ24
			txe_nxt = 1'b0;
		end
		if (tx_enable && tfall) begin
			if (tx_act_r) begin
				td_nxt = msb_first ? tsr_r[WORD_W-1] : tsr_r[0]; // RQ15
				tsr_nxt = msb_first ? {tsr_r[WORD_W-2:0], 1'b0} : {1'b0, tsr_r[WORD_W-1:1]};
				if (tcnt_r == LEN_W'(1)) begin
					tx_act_nxt = 1'b0;
				end
				tcnt_nxt = tcnt_r - 1'b1;
			end else if (thr_full_r && tx_go && !thr_write) begin // RQ14
				tsr_nxt = msb_first ? (thr_r << (WORD_W - int'(word_len))) : thr_r;
				thr_full_nxt = 1'b0;
				tx_act_nxt = 1'b1;
				tcnt_nxt = word_len;
				transmit_ready_flag_nxt = 1'b1; // RQ17
			end
		end
		if (!thr_full_nxt && !tx_act_nxt && !thr_write) begin
			txe_nxt = 1'b1; // RQ16
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			thr_r <= '0;
			tsr_r <= '0;
			thr_full_r <= 1'b0;
			tx_act_r <= 1'b0;
			tcnt_r <= '0;
			transmit_ready_flag_r <= 1'b1;
			txe_r <= 1'b1;
			td_r <= 1'b0;
		end else begin
			thr_r <= thr_nxt;
			tsr_r <= tsr_nxt;
			thr_full_r <= thr_full_nxt;
			tx_act_r <= tx_act_nxt;
			tcnt_r <= tcnt_nxt;
			transmit_ready_flag_r <= transmit_ready_flag_nxt;
			txe_r <= txe_nxt;
			td_r <= td_nxt;
		end
	end
	assign tx_serial_out = td_r;
	// Receive datapath; samples on rising edge of internal clock
	logic [WORD_W-1:0] rsr_r, rsr_nxt, rhr_r, rhr_nxt;
	logic rx_act_r, rx_act_nxt, receive_ready_flag_r, receive_ready_flag_nxt, ovr_r, ovr_nxt;
	logic [LEN_W-1:0] rcnt_r, rcnt_nxt;
	logic rd_in, rfs, rfs_prev, rx_go;
	assign rd_in = loopback ? td_r : rd_s; // RQ22
	assign rfs = loopback ? tf_s : rf_s;
	assign rfs_prev = loopback ? tf_p : rf_p;
	assign rx_start_ev_tx = rx_enable && rrise && !rx_act_r && rx_go;
	always_comb begin
		unique case (rx_start)
			ssc_pkg::SSC_START_CONT: rx_go = 1'b1;
			ssc_pkg::SSC_START_OTHER: rx_go = tx_act_r; // RQ13
			ssc_pkg::SSC_START_FS_RISE: rx_go = rfs & ~rfs_prev;
			ssc_pkg::SSC_START_FS_FALL: rx_go = ~rfs & rfs_prev;
		endcase
	end
	always_comb begin
		rsr_nxt = rsr_r;
		rhr_nxt = rhr_r;
		rx_act_nxt = rx_act_r;
		rcnt_nxt = rcnt_r;
		receive_ready_flag_nxt = receive_ready_flag_r;
		ovr_nxt = ovr_r;
		if (rhr_read) begin
			receive_ready_flag_nxt = 1'b0; // RQ24
		end
		if (rx_enable && rrise) begin
			if (!rx_act_r && rx_go) begin // RQ18
				rx_act_nxt = 1'b1;
				rcnt_nxt = word_len;
				rsr_nxt = '0;
			end else if (rx_act_r) begin
				rsr_nxt = msb_first ? {rsr_r[WORD_W-2:0], rd_in}
					: {rd_in, rsr_r[WORD_W-1:1]};
				rcnt_nxt = rcnt_r - 1'b1;
				if (rcnt_r == LEN_W'(1)) begin
					rx_act_nxt = 1'b0;
					rhr_nxt = msb_first ? rsr_nxt
						: (rsr_nxt >> (WORD_W - int'(word_len))); // RQ19
					receive_ready_flag_nxt = 1'b1;
					if (receive_ready_flag_r && !rhr_read) begin
						ovr_nxt = 1'b1; // RQ20
					end
				end
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rsr_r <= '0;
			rhr_r <= '0;
			rx_act_r <= 1'b0;
			rcnt_r <= '0;
			receive_ready_flag_r <= 1'b0;
			ovr_r <= 1'b0;
		end else begin
			rsr_r <= rsr_nxt;
			rhr_r <= rhr_nxt;
			rx_act_r <= rx_act_nxt;
			rcnt_r <= rcnt_nxt;
			receive_ready_flag_r <= receive_ready_flag_nxt;
			ovr_r <= ovr_nxt;
		end
	end
	assign rhr_rdata = rhr_r;
	// Interrupt mask and status
	logic [`SSC_ST_W-1:0] mask_r, mask_nxt;
	always_comb begin
		mask_nxt = (mask_r | int_enable_wr) & ~int_disable_wr; // RQ23
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mask_r <= '0;
		end else begin
			mask_r <= mask_nxt;
		end
	end
	always_comb begin
		status = '0;
		status[`SSC_ST_TRANSMIT_READY_FLAG] = transmit_ready_flag_r;
		status[`SSC_ST_TRANSMITTER_EMPTY_FLAG] = txe_r;
		status[`SSC_ST_RECEIVE_READY_FLAG] = receive_ready_flag_r;
		status[`SSC_ST_OVR] = ovr_r;
	end
	assign int_mask = mask_r;
	assign irq = |(status & mask_r); // RQ21
	// Clock pin drivers, taken before inversion
	assign tx_bit_clock_pin_out = tk_lvl; // RQ8
	assign rx_bit_clock_pin_out = rk_lvl;
	assign tx_bit_clock_pin_oe = (tx_cko == ssc_pkg::SSC_CKO_CONT)
		| ((tx_cko == ssc_pkg::SSC_CKO_XFER) & tx_act_r); // RQ9
	assign rx_bit_clock_pin_oe = (rx_cko == ssc_pkg::SSC_CKO_CONT)
		| ((rx_cko == ssc_pkg::SSC_CKO_XFER) & rx_act_r); // RQ9
	assign tx_busy = tx_act_r;
	assign rx_busy = rx_act_r;
	logic unused_ok;
	assign unused_ok = tclk ^ rclk ^ tfs;
endmodule
`default_nettype wire

/* tb/ssc_core_props.sv */
// Port assertions for the serial clock and shift core
`timescale 1ns/1ps
`default_nettype none
`include "ssc_cfg.svh"
module ssc_core_props #(
	parameter int DIV_W = 12,
	parameter int WORD_W = 32
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [DIV_W-1:0] clock_ratio,
	input wire ssc_pkg::ssc_src_t tx_src,
	input wire ssc_pkg::ssc_cko_t tx_cko,
	input wire logic thr_write,
	input wire logic rhr_read,
	input wire logic [WORD_W-1:0] rhr_rdata,
	input wire logic [`SSC_ST_W-1:0] int_enable_wr,
	input wire logic [`SSC_ST_W-1:0] int_disable_wr,
	input wire logic [`SSC_ST_W-1:0] int_mask,
	input wire logic [`SSC_ST_W-1:0] status,
	input wire logic irq,
	input wire logic tx_bit_clock_pin_out,
	input wire logic tx_bit_clock_pin_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	logic last_r;
	logic [DIV_W:0] run_r;
	logic [1:0] ph_r;
	logic cont;
	assign cont = tx_cko == ssc_pkg::SSC_CKO_CONT && tx_src != ssc_pkg::SSC_SRC_PIN;
	// Length of the current pin clock phase, restarted on a ratio or transmit source change or when output is not continuous
	always_ff @(posedge clk) begin
		last_r <= tx_bit_clock_pin_out;
		if (!rstn || !cont || $changed(clock_ratio) || $changed(tx_src)) begin
			run_r <= '0;
			ph_r <= 2'h0;
		end else if (tx_bit_clock_pin_out != last_r) begin
			run_r <= {{DIV_W{1'b0}}, 1'b1};
			ph_r <= (ph_r == 2'h3) ? ph_r : ph_r + 2'h1;
		end else begin
			run_r <= run_r + {{DIV_W{1'b0}}, 1'b1};
		end
	end
	property p_div;
		cont && tx_bit_clock_pin_out != last_r && ph_r >= 2'h2 && !$changed(clock_ratio)
			|-> run_r == {1'b0, clock_ratio};
	endproperty
	a_div: assert property (p_div) else $error("divided phase length wrong");
	property p_zero;
		(cont && clock_ratio == '0)[*6] |=> $stable(tx_bit_clock_pin_out);
	endproperty
	a_zero: assert property (p_zero) else $error("clock with ratio zero");
	property p_oe;
		(tx_cko == ssc_pkg::SSC_CKO_CONT)[*2] |-> tx_bit_clock_pin_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("clock pin not driven");
	property p_irq;
		irq == |(status & int_mask);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");
	property p_en;
		int_enable_wr != '0 && int_disable_wr == '0
			|=> (int_mask & $past(int_enable_wr)) == $past(int_enable_wr);
	endproperty
	a_en: assert property (p_en) else $error("mask bit not set");
	property p_dis;
		int_disable_wr != '0 && int_enable_wr == '0 |=> (int_mask & $past(int_disable_wr)) == '0;
	endproperty
	a_dis: assert property (p_dis) else $error("mask bit not cleared");
	property p_hold;
		int_enable_wr == '0 && int_disable_wr == '0 |=> $stable(int_mask);
	endproperty
	a_hold: assert property (p_hold) else $error("mask changed");
	property p_thr;
		thr_write |=> !status[`SSC_ST_TRANSMIT_READY_FLAG] && !status[`SSC_ST_TRANSMITTER_EMPTY_FLAG];
	endproperty
	a_thr: assert property (p_thr) else $error("tx flags not cleared");
	property p_rd;
		rhr_read |=> !status[`SSC_ST_RECEIVE_READY_FLAG] || $changed(rhr_rdata);
	endproperty
	a_rd: assert property (p_rd) else $error("rx ready not cleared");
	property p_ovr;
		status[`SSC_ST_OVR] |=> status[`SSC_ST_OVR];
	endproperty
	a_ovr: assert property (p_ovr) else $error("overflow lost");
endmodule
bind ssc_core ssc_core_props #(.DIV_W(DIV_W), .WORD_W(WORD_W)) ssc_core_props_inst (.clk, .rstn,
	.clock_ratio, .tx_src, .tx_cko, .thr_write, .rhr_read, .rhr_rdata, .int_enable_wr,
	.int_disable_wr, .int_mask, .status, .irq, .tx_bit_clock_pin_out, .tx_bit_clock_pin_oe);
`default_nettype wire

/* tb/ssc_codec.sv */
// Behavioural codec on the far side of the serial pins
`timescale 1ns/1ps
`default_nettype none
module ssc_codec (
	input wire logic clk,
	input wire logic tx_clk_out,
	input wire logic tx_clk_oe,
	input wire logic rx_clk_out,
	input wire logic rx_clk_oe,
	input wire logic tx_data,
	output logic tx_clk_in,
	output logic rx_clk_in,
	output logic rx_data,
	output logic tx_fs,
	output logic rx_fs
);
	logic [1:0] cnt_r = 2'h0;
	logic pat_r = 1'b0;
	always_ff @(posedge clk) begin
		cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
		pat_r <= (cnt_r == 2'h2) ? ~pat_r : pat_r;
	end
	// Undriven clock pins take the pattern, which runs at system clock over six
	assign tx_clk_in = tx_clk_oe ? tx_clk_out : pat_r;
	assign rx_clk_in = rx_clk_oe ? rx_clk_out : pat_r;
	// Echoes the transmit line back
	assign rx_data = tx_data;
	// Frame sync follows the pattern, so its rise meets the clock rise
	assign tx_fs = pat_r;
	assign rx_fs = 1'b0;
endmodule
`default_nettype wire

/* tb/ssc_core_bench.sv */
// Self-checking bench for the serial clock and shift core
`timescale 1ns/1ps
`default_nettype none
module ssc_core_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [11:0] clock_ratio = 12'h000;
	ssc_pkg::ssc_src_t tx_src = ssc_pkg::SSC_SRC_DIV;
	ssc_pkg::ssc_src_t rx_src = ssc_pkg::SSC_SRC_DIV;
	ssc_pkg::ssc_cko_t tx_cko = ssc_pkg::SSC_CKO_CONT;
	ssc_pkg::ssc_cko_t rx_cko = ssc_pkg::SSC_CKO_NONE;
	ssc_pkg::ssc_start_t tx_start = ssc_pkg::SSC_START_CONT;
	ssc_pkg::ssc_start_t rx_start = ssc_pkg::SSC_START_OTHER;
	logic tx_invert = 1'b0, rx_invert = 1'b0, msb_first = 1'b1, loopback = 1'b0;
	logic tx_enable = 1'b0, rx_enable = 1'b0, thr_write = 1'b0, rhr_read = 1'b0;
	logic [5:0] word_len = 6'h08;
	logic [31:0] thr_wdata = 32'h0, rhr_rdata;
	logic [3:0] int_enable_wr = 4'h0, int_disable_wr = 4'h0, int_mask, status;
	logic irq, tx_bit_clock_pin_in, tx_bit_clock_pin_out, tx_bit_clock_pin_oe;
	logic rx_bit_clock_pin_in, rx_bit_clock_pin_out, rx_bit_clock_pin_oe;
	logic tx_frame_sync_pin_in, rx_frame_sync_pin_in, rx_serial_in, tx_serial_out;
	logic tx_busy, rx_busy;
	logic [31:0] exp_q[$];
	logic last_busy = 1'b0;
	logic [7:0] a;
	int err_total = 0, n_compared = 0, cyc = 0, seed;
	initial forever #5 clk = ~clk;
	ssc_core ssc_core_inst (.clk, .rstn, .clock_ratio, .tx_src, .rx_src, .tx_invert, .rx_invert,
		.tx_cko, .rx_cko, .tx_start, .rx_start, .word_len, .msb_first, .tx_enable, .rx_enable,
		.loopback, .thr_wdata, .thr_write, .rhr_rdata, .rhr_read, .int_enable_wr, .int_disable_wr,
		.int_mask, .status, .irq, .tx_bit_clock_pin_in, .tx_bit_clock_pin_out, .tx_bit_clock_pin_oe,
		.rx_bit_clock_pin_in, .rx_bit_clock_pin_out, .rx_bit_clock_pin_oe, .tx_frame_sync_pin_in,
		.rx_frame_sync_pin_in, .rx_serial_in, .tx_serial_out, .tx_busy, .rx_busy);
	ssc_codec ssc_codec_inst (.clk(clk), .tx_clk_out(tx_bit_clock_pin_out),
		.tx_clk_oe(tx_bit_clock_pin_oe), .rx_clk_out(rx_bit_clock_pin_out),
		.rx_clk_oe(rx_bit_clock_pin_oe), .tx_data(tx_serial_out), .tx_clk_in(tx_bit_clock_pin_in),
		.rx_clk_in(rx_bit_clock_pin_in), .rx_data(rx_serial_in), .tx_fs(tx_frame_sync_pin_in),
		.rx_fs(rx_frame_sync_pin_in));
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			report_and_stop;
		end
	end
	// A finished receive word is matched against the oldest sent one
	always @(posedge clk) begin
		if (!last_busy && rx_busy) begin
			chk(rx_bit_clock_pin_oe, rx_cko != ssc_pkg::SSC_CKO_NONE);
			chk(tx_busy, 1'b1);
		end
		if (last_busy && !rx_busy) begin
			if (exp_q.size() > 0) chk(rhr_rdata, exp_q.pop_front());
			else begin
				err_total++;
				$display("ERROR %0t got %h expected %h", $time, rhr_rdata, 32'h0);
			end
		end
		last_busy = rx_busy;
	end
	task phase(input logic [11:0] r, input int k);
		int hi, tog;
		logic last;
		hi = 0;
		tog = 0;
		clock_ratio <= r;
		repeat (30) @(posedge clk);
		last = tx_bit_clock_pin_out;
		repeat ((r != 0) ? 2 * k * r : 64) begin
			@(posedge clk);
			hi += tx_bit_clock_pin_out + rx_bit_clock_pin_out;
			tog += (tx_bit_clock_pin_out != last);
			last = tx_bit_clock_pin_out;
		end
		chk(tog, (r != 0) ? 2 * k : 0);
		if (r != 0) chk(hi, 2 * k * r);
	endtask
	task pulse(input logic [3:0] en, input logic [3:0] dis);
		int_enable_wr <= en;
		int_disable_wr <= dis;
		@(posedge clk);
		int_enable_wr <= 4'h0;
		int_disable_wr <= 4'h0;
		repeat (2) @(posedge clk);
	endtask
	task wait_bit(input int b, input logic v);
		int n;
		n = 0;
		while (status[b] !== v && n < 500) begin
			@(posedge clk);
			n++;
		end
		chk(status[b], v);
	endtask
	task send(input logic [7:0] b);
		wait_bit(0, 1'b1);
		thr_wdata <= {24'h0, b};
		thr_write <= 1'b1;
		exp_q.push_back({24'h0, b});
		@(posedge clk);
		thr_write <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		seed = $urandom(66);
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		chk(status, 4'h3);
		pulse(4'h2, 4'h0);
		chk({int_mask, 3'h0, irq}, 32'h21);
		pulse(4'h1, 4'h2);
		chk({int_mask, 3'h0, irq}, 32'h11);
		pulse(4'h0, 4'h1);
		chk({int_mask, 3'h0, irq}, 32'h00);
		// Own pin with continuous output is never selected
		phase(12'h001, 8);
		tx_invert <= 1'b1;
		phase(12'h003, 8);
		tx_invert <= 1'b0;
		tx_src <= ssc_pkg::SSC_SRC_OTHER;
		phase(12'h002, 8);
		tx_src <= ssc_pkg::SSC_SRC_DIV;
		phase(12'($urandom_range(4, 12)), 8);
		phase(12'h000, 1);
		phase(12'hfff, 1);
		clock_ratio <= 12'h001;
		rx_src <= ssc_pkg::SSC_SRC_OTHER;
		tx_cko <= ssc_pkg::SSC_CKO_XFER;
		rx_cko <= ssc_pkg::SSC_CKO_XFER;
		loopback <= 1'b1;
		tx_enable <= 1'b1;
		rx_enable <= 1'b1;
		pulse(4'h8, 4'h0);
		a = 8'($urandom_range(1, 127));
		send(a);
		wait_bit(2, 1'b1);
		rhr_read <= 1'b1;
		@(posedge clk);
		rhr_read <= 1'b0;
		repeat (2) @(posedge clk);
		chk({status[2], irq}, 32'h0);
		send(a + 8'h80);
		send(~a);
		wait_bit(1, 1'b1);
		repeat (60) @(posedge clk);
		chk({status[3:2], irq}, 32'h7);
		// Receive from the codec's pin clock, both clocks inverted, lsb first
		loopback <= 1'b0;
		msb_first <= 1'b0;
		tx_invert <= 1'b1;
		rx_invert <= 1'b1;
		rx_cko <= ssc_pkg::SSC_CKO_NONE;
		rx_src <= ssc_pkg::SSC_SRC_PIN;
		tx_src <= ssc_pkg::SSC_SRC_OTHER;
		tx_start <= ssc_pkg::SSC_START_FS_RISE;
		word_len <= 6'($urandom_range(8, 32));
		repeat (8) @(posedge clk);
		send(8'($urandom()));
		wait_bit(1, 1'b1);
		repeat (20) @(posedge clk);
		chk(exp_q.size(), 0);
		report_and_stop;
	end
endmodule
`default_nettype wire
